/* hdl/if_frequency_counter.sv */
`timescale 1ns/10ps
`default_nettype none
module if_frequency_counter
    import ifc_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WR_DATA,
    input  wire logic              WR_EN,
    input  wire logic              RD_EN,
    output logic      [DATA_W-1:0] RD_DATA,
    input  wire logic              IF_IN,
    output logic                   IF_OUT,
    output logic                   IF_OE_N
);

    localparam int TW = $clog2(TICK_LEN + 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    ctrl_t                ctrl_q;
    ctrl_t                wr_ctrl;
    state_t               state_q;
    logic [COUNT_W-1:0]   count_q;
    logic [TW-1:0]        tick_cnt_q;
    logic                 tick;
    logic [3:0]           gate_left_q;
    logic                 inf_closed_q;
    logic [2:0]           if_sync_q;
    logic                 if_rise;
    logic                 ctrl_wr;
    logic                 start_wr;
    logic                 close_wr;
    logic                 resume_wr;
    logic                 busy;
    logic [DATA_W-1:0]    rd_data_q;

    // Gate length in ticks for a finite select code
    function automatic logic [3:0] gate_len(input logic [1:0] sel);
        unique case (sel)
            GATE_4MS: gate_len = TICKS_4MS;
            GATE_8MS: gate_len = TICKS_8MS;
            default:  gate_len = TICKS_1MS;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    // Control writes land at the shared address
    assign wr_ctrl   = ctrl_t'(WR_DATA);
    assign ctrl_wr   = WR_EN && (ADDR == CTRL_OFS);
    // Finite code while the unbounded gate is open closes it
    assign close_wr  = ctrl_wr && wr_ctrl.enable && wr_ctrl.clr_start
                       && (state_q == ST_GATE) && (ctrl_q.gate_sel == GATE_INF)
                       && (wr_ctrl.gate_sel != GATE_INF);
    // Unbounded code after such a close resumes without clearing
    assign resume_wr = ctrl_wr && wr_ctrl.enable && wr_ctrl.clr_start
                       && (state_q == ST_HOLD) && inf_closed_q
                       && (wr_ctrl.gate_sel == GATE_INF);
    // Any other enabled write with start set begins a fresh measurement, unless the unbounded gate is open
    assign start_wr  = ctrl_wr && wr_ctrl.enable && wr_ctrl.clr_start
                       && !close_wr && !resume_wr
                       && !((state_q == ST_GATE)
                            && (ctrl_q.gate_sel == GATE_INF));

    ////////////////////////////////////////////////////////////////////////
    // Control register, write only

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q <= ctrl_t'(CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl_q <= wr_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running basic tick, independent of software

    always_ff @(posedge CLK) begin
        if (RST) begin
            tick_cnt_q <= '0;
        end else if (tick) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + TW'(1);
        end
    end

    assign tick = (tick_cnt_q == TW'(TICK_LEN - 1));

    ////////////////////////////////////////////////////////////////////////
    // Input pin synchroniser and rising-edge detect

    always_ff @(posedge CLK) begin
        if (RST) begin
            if_sync_q <= 3'h0;
        end else begin
            if_sync_q <= {if_sync_q[1:0], IF_IN};
        end
    end

    // Third stage is the edge reference; first stage feeds only the second
    assign if_rise = if_sync_q[1] && !if_sync_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Gate sequencer

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
        end else if (ctrl_wr && (!wr_ctrl.enable || !wr_ctrl.clr_start)) begin
            state_q <= ST_IDLE;
        end else if (close_wr) begin
            state_q <= ST_HOLD;
        end else if (start_wr || resume_wr) begin
            state_q <= ST_ARM;
        end else begin
            unique case (state_q)
                ST_IDLE: state_q <= ST_IDLE;
                ST_ARM: begin
                    if (tick) begin
                        state_q <= ST_GATE;
                    end
                end
                ST_GATE: begin
                    if (tick && (ctrl_q.gate_sel != GATE_INF)
                        && (gate_left_q == 4'h1)) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: state_q <= ST_HOLD;
            endcase
        end
    end

    // Ticks remaining in a finite gate
    always_ff @(posedge CLK) begin
        if (RST) begin
            gate_left_q <= 4'h0;
        end else if (state_q == ST_ARM && tick) begin
            gate_left_q <= gate_len(ctrl_q.gate_sel);
        end else if (state_q == ST_GATE && tick && gate_left_q != 4'h0) begin
            gate_left_q <= gate_left_q - 4'h1;
        end
    end

    // Remembers that the hold came from closing an unbounded gate
    always_ff @(posedge CLK) begin
        if (RST) begin
            inf_closed_q <= 1'b0;
        end else if (close_wr) begin
            inf_closed_q <= 1'b1;
        end else if (ctrl_wr) begin
            inf_closed_q <= 1'b0;
        end
    end

    // Busy covers arming and an open gate; unbounded mode makes it moot
    assign busy = (state_q == ST_ARM) || (state_q == ST_GATE);

    ////////////////////////////////////////////////////////////////////////
    // Pulse counter

    always_ff @(posedge CLK) begin
        if (RST) begin
            count_q <= COUNT_RESET;
        end else if (ctrl_wr && !wr_ctrl.clr_start) begin
            count_q <= COUNT_RESET;
        end else if (start_wr) begin
            count_q <= COUNT_RESET;
        end else if (state_q == ST_GATE && if_rise) begin
            count_q <= count_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin pull-down while disabled

    assign IF_OUT  = 1'b0;
    assign IF_OE_N = ctrl_q.enable;

    ////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe

    always_ff @(posedge CLK) begin
        if (RST) begin
            rd_data_q <= 4'h0;
        end else if (RD_EN) begin
            unique case (ADDR)
                CTRL_OFS:   rd_data_q <= {3'h0, busy};
                DIGIT0_OFS: rd_data_q <= count_q[3:0];
                DIGIT1_OFS: rd_data_q <= count_q[7:4];
                DIGIT2_OFS: rd_data_q <= count_q[11:8];
                DIGIT3_OFS: rd_data_q <= count_q[15:12];
                default:    rd_data_q <= 4'h0;
            endcase
        end else begin
            rd_data_q <= 4'h0;
        end
    end

    assign RD_DATA = rd_data_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Start and clear
    start_sets_busy_a: assert property (@(posedge CLK)
        disable iff (RST) start_wr |=> busy ##0 (count_q == 16'h0000))
        else $error("Start did not raise busy with a cleared count");

    clear_zeroes_a: assert property (@(posedge CLK)
        disable iff (RST) (ctrl_wr && !wr_ctrl.clr_start) |=>
            (count_q == 16'h0000) && !busy)
        else $error("Clear did not zero the counter");

    // Disable and control writes
    disable_idles_a: assert property (@(posedge CLK)
        disable iff (RST) (ctrl_wr && !wr_ctrl.enable) |=>
            (state_q == ST_IDLE) && !busy)
        else $error("Disable write left the gate running");

    ctrl_write_a: assert property (@(posedge CLK)
        disable iff (RST) ctrl_wr |=> (ctrl_q == $past(wr_ctrl)))
        else $error("Control write did not land");

    // Basic tick and gate timing
    tick_restart_a: assert property (@(posedge CLK)
        disable iff (RST) tick |=> (tick_cnt_q == TW'(0)))
        else $error("Tick counter did not restart after a tick");

    tick_step_a: assert property (@(posedge CLK)
        disable iff (RST) (!RST && !tick) |=>
            (tick_cnt_q == $past(tick_cnt_q) + TW'(1)))
        else $error("Tick counter skipped a cycle");

    gate_on_tick_a: assert property (@(posedge CLK)
        disable iff (RST) (state_q == ST_ARM && !ctrl_wr) |=>
            ((state_q == ST_GATE) == $past(tick)))
        else $error("Gate opened off the basic tick");

    // Finite and unbounded gates
    finite_gate_ends_a: assert property (@(posedge CLK)
        disable iff (RST) (state_q == ST_GATE && tick && !ctrl_wr
         && ctrl_q.gate_sel != GATE_INF && gate_left_q == 4'h1) |=>
            (state_q == ST_HOLD) && !busy)
        else $error("Finite gate did not close on its last tick");

    unbounded_stays_a: assert property (@(posedge CLK)
        disable iff (RST) (state_q == ST_GATE && !ctrl_wr
         && ctrl_q.gate_sel == GATE_INF) |=> (state_q == ST_GATE))
        else $error("Unbounded gate closed without a write");

    // Unbounded close and resume
    close_holds_a: assert property (@(posedge CLK)
        disable iff (RST) close_wr |=> (state_q == ST_HOLD) && !busy)
        else $error("Closing write did not hold the unbounded gate");

    resume_keeps_a: assert property (@(posedge CLK)
        disable iff (RST) resume_wr |=>
            (state_q == ST_ARM) && $stable(count_q))
        else $error("Resume did not rearm with the count kept");

    // Counting and hold
    pulse_counted_a: assert property (@(posedge CLK)
        disable iff (RST) (state_q == ST_GATE && if_rise && !ctrl_wr) |=>
            (count_q == $past(count_q) + 16'h0001))
        else $error("Gated input pulse not counted");

    closed_gate_stable_a: assert property (@(posedge CLK)
        disable iff (RST) (state_q != ST_GATE && !ctrl_wr) |=>
            $stable(count_q))
        else $error("Count changed outside the gate");

    // Pin pull-down
    pin_pulled_a: assert property (@(posedge CLK)
        disable iff (RST) !ctrl_q.enable |-> !IF_OE_N && !IF_OUT)
        else $error("Disabled input pin not pulled low");

    // Status read
    status_read_a: assert property (@(posedge CLK)
        disable iff (RST) (RD_EN && ADDR == CTRL_OFS) |=>
            (RD_DATA == {3'h0, $past(busy)}))
        else $error("Status read did not return busy");

    // Digit reads
    digit0_read_a: assert property (@(posedge CLK)
        disable iff (RST) (RD_EN && ADDR == DIGIT0_OFS) |=>
            (RD_DATA == $past(count_q[3:0])))
        else $error("Lowest digit read returned wrong nibble");

    digit1_read_a: assert property (@(posedge CLK)
        disable iff (RST) (RD_EN && ADDR == DIGIT1_OFS) |=>
            (RD_DATA == $past(count_q[7:4])))
        else $error("Second digit read returned wrong nibble");

    digit2_read_a: assert property (@(posedge CLK)
        disable iff (RST) (RD_EN && ADDR == DIGIT2_OFS) |=>
            (RD_DATA == $past(count_q[11:8])))
        else $error("Third digit read returned wrong nibble");

    top_digit_read_a: assert property (@(posedge CLK)
        disable iff (RST) (RD_EN && ADDR == DIGIT3_OFS) |=>
            (RD_DATA == $past(count_q[15:12])))
        else $error("Top digit read returned wrong nibble");

    // Unmapped and idle reads
    unmapped_read_a: assert property (@(posedge CLK)
        disable iff (RST)
            (RD_EN && (ADDR < CTRL_OFS || ADDR > DIGIT3_OFS)) |=>
            (RD_DATA == 4'h0))
        else $error("Unmapped read returned nonzero data");

    read_idle_a: assert property (@(posedge CLK)
        disable iff (RST) !RD_EN |=> (RD_DATA == 4'h0))
        else $error("Read data stood beyond its cycle");

    // Main scenarios
    finite_done_c: cover property (@(posedge CLK) disable iff (RST)
        (state_q == ST_GATE && ctrl_q.gate_sel == GATE_8MS) ##1
            (state_q == ST_HOLD));

    finite_1ms_c: cover property (@(posedge CLK) disable iff (RST)
        (state_q == ST_GATE && ctrl_q.gate_sel == GATE_1MS) ##1
            (state_q == ST_HOLD));

    clear_c: cover property (@(posedge CLK) disable iff (RST)
        (ctrl_wr && !wr_ctrl.clr_start) ##1 (count_q == COUNT_RESET));

    unbounded_close_c: cover property (@(posedge CLK) disable iff (RST)
        close_wr ##1 (state_q == ST_HOLD));

    resume_c: cover property (@(posedge CLK) disable iff (RST)
        resume_wr ##1 (state_q == ST_ARM));

endmodule
`default_nettype wire

/* hdl/ifc_pkg.sv */
// Functional notes
// - 16-bit counter counts gated input pulses, readable.
// - Counts input pulses up to 15 MHz.
// - Gate select picks 1, 4, 8 ms or unbounded.
// - Clear-start zero clears; one starts counting.
// - Start sets busy; busy drops when gate ends.
// - Gate timing from free-running 1 ms tick.
// - Counting begins at next tick after start.
// - Unbounded gate counts until selection changes.
// - Busy flag meaningless in unbounded mode.
// - Disabled counter pulls input pin to ground.
// - Control register: four write-only bits.
// - Four read-only digits, highest address most significant.
// - Read-only status shares control register address.
package ifc_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 4;
    localparam int          COUNT_W       = 16;

    // Register offsets
    localparam logic [7:0]  CTRL_OFS      = 8'h28;
    localparam logic [7:0]  DIGIT0_OFS    = 8'h29;
    localparam logic [7:0]  DIGIT1_OFS    = 8'h2A;
    localparam logic [7:0]  DIGIT2_OFS    = 8'h2B;
    localparam logic [7:0]  DIGIT3_OFS    = 8'h2C;

    // Control field positions
    localparam int          CTRL_EN_BIT   = 3;
    localparam int          CTRL_CS_BIT   = 2;

    // Gate select codes
    localparam logic [1:0]  GATE_1MS      = 2'h0;
    localparam logic [1:0]  GATE_4MS      = 2'h1;
    localparam logic [1:0]  GATE_8MS      = 2'h2;
    localparam logic [1:0]  GATE_INF      = 2'h3;

    // Gate lengths in basic ticks
    localparam logic [3:0]  TICKS_1MS     = 4'h1;
    localparam logic [3:0]  TICKS_4MS     = 4'h4;
    localparam logic [3:0]  TICKS_8MS     = 4'h8;

    // Reset values
    localparam logic [3:0]  CTRL_RESET    = 4'h0;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // Basic tick timing
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          TICK_TIME_NS  = 1000000;
    localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic       enable;
        logic       clr_start;
        logic [1:0] gate_sel;
    } ctrl_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM  = 4'b0010,
        ST_GATE = 4'b0100,
        ST_HOLD = 4'b1000
    } state_t;

endpackage

/* testbench/if_source.sv */
`timescale 1ns/10ps
`default_nettype none
// Free-running tuner signal, one pulse every 17 clocks (about 14.7 MHz)
module if_source (
    input  wire logic CLK,
    output logic      IF_SIG
);
    logic [4:0] ph_q = 5'h00;

    // Phase counter keeps the rate under the 15 MHz ceiling
    always_ff @(posedge CLK) begin
        ph_q <= (ph_q == 5'h10) ? 5'h00 : ph_q + 5'h01;
    end

    // High for 8 clocks, low for 9
    assign IF_SIG = (ph_q < 5'h08);
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ifc_pkg::*;
    localparam int TL = 68;
    logic              CLK;
    logic              RST = 1'b1;
    logic              WR_EN = 1'b0;
    logic              RD_EN = 1'b0;
    logic [ADDR_W-1:0] ADDR = 8'h00;
    logic [DATA_W-1:0] WR_DATA = 4'h0;
    logic [DATA_W-1:0] RD_DATA;
    logic              IF_OUT;
    logic              IF_OE_N;
    logic              src;
    logic              if_pin;
    logic [3:0]        d;
    logic [15:0]       c0;
    logic [15:0]       c1;
    int                n;
    int                k;
    int                err_count = 0;
    int                comparisons = 0;

    // Pin level: grounded by the block unless it releases the pin
    assign if_pin = IF_OE_N ? src : IF_OUT;

    if_frequency_counter #(.TICK_LEN(TL)) DUT (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
        .IF_IN(if_pin), .IF_OUT(IF_OUT), .IF_OE_N(IF_OE_N)
    );

    if_source SRC (.CLK(CLK), .IF_SIG(src));

    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] v);
        @(posedge CLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WR_DATA <= v;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [3:0] v);
        @(posedge CLK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1 v = RD_DATA;
    endtask

    // Whole count from the four digits, lowest address first
    task automatic rdc(output logic [15:0] v);
        logic [3:0] x;
        for (int i = 0; i < 4; i++) begin
            rd(DIGIT0_OFS + 8'(i), x);
            v[4*i +: 4] = x;
        end
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog against a hung poll
    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        // Disabled after reset: pin held low while the source toggles
        wait (src === 1'b1);
        chk({15'h0000, if_pin}, 16'h0000);
        rdc(c0);
        chk(c0, 16'h0000);
        // Finite gates: busy, completion time, count, hold
        for (int g = 0; g < 3; g++) begin
            n = (g == 0) ? 1 : g * 4;
            wr(CTRL_OFS, {2'b11, 2'(g)});
            #1;
            chk({15'h0000, IF_OE_N}, 16'h0001);
            rd(CTRL_OFS, d);
            chk({12'h000, d}, 16'h0001);
            k = 0;
            while (d[0] !== 1'b0 && k < 400) begin
                rd(CTRL_OFS, d);
                k++;
            end
            chk(16'(k >= n*TL/2 - 2 && k <= (n+1)*TL/2 + 2), 16'h0001);
            rdc(c0);
            chk(c0, 16'(n * 4));
            repeat (2 * TL) @(posedge CLK);
            rdc(c1);
            chk(c1, c0);
        end
        // Read-only digits and unmapped address
        wr(DIGIT0_OFS, 4'hF);
        rdc(c1);
        chk(c1, c0);
        rd(8'h30, d);
        chk({12'h000, d}, 16'h0000);
        // Clear-start low clears the count
        wr(CTRL_OFS, 4'h8);
        rdc(c0);
        chk(c0, 16'h0000);
        rd(CTRL_OFS, d);
        chk({12'h000, d}, 16'h0000);
        // Unbounded gate, closed by a finite code, then resumed
        wr(CTRL_OFS, 4'hF);
        repeat (3 * TL) @(posedge CLK);
        wr(CTRL_OFS, 4'hC);
        rdc(c0);
        chk(16'(c0 >= 16'h0007 && c0 <= 16'h000D), 16'h0001);
        repeat (TL) @(posedge CLK);
        rdc(c1);
        chk(c1, c0);
        wr(CTRL_OFS, 4'hF);
        repeat (3 * TL) @(posedge CLK);
        wr(CTRL_OFS, 4'hD);
        rdc(c1);
        chk(16'(c1 - c0 >= 16'h0007 && c1 - c0 <= 16'h000D), 16'h0001);
        // Disable with clear-start kept: idle, count kept
        wr(CTRL_OFS, 4'h4);
        rdc(c0);
        chk(c0, c1);
        rd(CTRL_OFS, d);
        chk({12'h000, d}, 16'h0000);
        // Disable before stop: pin grounded again
        wr(CTRL_OFS, 4'h0);
        @(posedge CLK);
        wait (src === 1'b1);
        #1;
        chk({14'h0000, IF_OE_N, if_pin}, 16'h0000);
        give_verdict();
    end
endmodule
`default_nettype wire
